/* File: disc_top.sv */
// Input sync, channel steering, midscale forcing and pin roles of a dual DAC.
// Assumes a 125 MHz data clock, an APB master and a downstream datapath that drains the FIFO.
// How it works
// - Select 0: strobe high clears the phase accumulator, nothing else.
// - Select 1 and external clock: strobe rising edge aligns the divided clock.
// - Select 1: strobe high also clears the phase accumulator.
// - PLL mode: lock indicator high while the PLL reports lock.
// - External clock mode: lock indicator carries the divided input-rate clock.
// - Interleaved with flag enabled: flag high marks the word as channel B.
// - Chip reset low resets all logic except the sleep output.
// - Three-pin serial: data pin two-way; four-pin: input only.
// - Serial out pin idle in three-pin mode; read data in four-pin mode.
// - Serial enable is active low and only ever an input.
// - Sleep high powers down at once, without a clock.
// - Interleaved: first word after enable rise is A, then B, alternating.
// - Transmit enable low forces both outputs to midscale.
// - Reverse setting flips the channel B bus bit order.
// - Input data is captured on the data clock.
`timescale 1ns/100ps
`default_nettype none
`include "disc_defs.svh"

module disc_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    // Write side
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic             wvalid_i,
    output logic                  wready_o,
    // Read side
    output logic      [WIDTH-1:0] rdata_o,
    output logic                  rvalid_o,
    input  wire logic             rready_i
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("disc_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;
    logic             do_wr;
    logic             do_rd;
    assign wready_o = (wptr - rptr) != (AW+1)'(DEPTH);
    assign rvalid_o = wptr != rptr;
    assign rdata_o  = mem[rptr[AW-1:0]];
    assign do_wr    = ce_i && wvalid_i && wready_o;
    assign do_rd    = ce_i && rvalid_o && rready_i;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wptr <= '0;
        else if (do_wr)
            wptr <= wptr + 1'b1;
    end
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rptr <= '0;
        else if (do_rd)
            rptr <= rptr + 1'b1;
    end
    always_ff @(posedge clock_i)
    begin
        if (do_wr)
            mem[wptr[AW-1:0]] <= wdata_i;
    end
endmodule : disc_fifo

module disc_top
#(
    parameter int DEPTH = 32
)
(
    // Clock, enable and reset
    input  wire logic                   clock_i,
    input  wire logic                   ce_i,
    input  wire logic                   rstn_i,
    // Chip control pins
    input  wire logic                   chip_reset_n_i,
    input  wire logic                   sleep_i,
    input  wire logic                   test_select_i,
    input  wire logic                   pll_locked_i,
    // Sync pins
    input  wire logic                   phase_strobe_i,
    input  wire logic                   transmit_enable_i,
    input  wire logic                   channel_flag_i,
    // Data input
    input  wire disc_pkg::disc_word_type channel_a_data_i,
    input  wire disc_pkg::disc_word_type channel_b_data_i,
    // APB slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Serial port pins
    input  wire logic                   serial_port_enable_n_i,
    input  wire logic                   serial_data_i,
    output logic                        serial_data_o,
    output logic                        serial_data_oe_o,
    output logic                        serial_data_out_o,
    output logic                        serial_data_out_oe_o,
    // Status outputs
    output logic                        lock_indicator_o,
    output logic                        phase_clear_o,
    output logic                        sleep_o,
    // Sample stream, A in high half, B in low half
    output logic      [31:0]            sample_o,
    output logic                        sample_valid_o,
    input  wire logic                   sample_ready_i
);
    import disc_pkg::*;

    logic          rst_n;
    logic [31:0]   ctrl;
    logic [7:0]    div_count;
    logic [1:0]    ser_ctl;
    logic [31:0]   ser_rd;
    logic [1:0]    ps_sync;
    logic [1:0]    te_sync;
    logic          ps_q;
    logic          te_q;
    logic          ps_rise;
    logic          te_rise;
    logic [7:0]    div_cnt;
    logic          div_clk;
    disc_chan_type chan;
    disc_word_type a_hold;
    disc_word_type b_in;
    disc_word_type next_a;
    disc_word_type next_b;
    logic          pair_valid;
    logic          fifo_wready;
    logic [31:0]   fifo_rdata;
    logic          fifo_rvalid;
    logic          apb_acc;
    logic          ce;

    initial
    begin
        if (DEPTH != 32)
            $error("disc_top buffering is sized for 32 words");
    end

    assign rst_n = rstn_i & chip_reset_n_i;
    assign ce    = ce_i & ~sleep_i;

    // Synchronisers and edge detect
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ps_sync <= 2'b00;
            te_sync <= 2'b00;
            ps_q    <= 1'b0;
            te_q    <= 1'b0;
        end
        else if (ce)
        begin
            ps_sync <= {ps_sync[0], phase_strobe_i};
            te_sync <= {te_sync[0], transmit_enable_i};
            ps_q    <= ps_sync[1];
            te_q    <= te_sync[1];
        end
    end
    assign ps_rise = ps_sync[1] & ~ps_q;
    assign te_rise = te_sync[1] & ~te_q;

    // Phase accumulator clear, high level in either select
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            phase_clear_o <= 1'b0;
        else if (ce)
            phase_clear_o <= ps_sync[1];
    end

    // Divided input-rate clock with strobe alignment
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 8'h00;
            div_clk <= 1'b0;
        end
        else if (ce)
        begin
            if (ctrl[`DISC_CTRL_SYNCSEL] && ctrl[`DISC_CTRL_EXTCLK] && ps_rise)
            begin
                div_cnt <= 8'h00;
                div_clk <= 1'b0;
            end
            else if (div_cnt >= div_count - 8'h01)
            begin
                div_cnt <= 8'h00;
                div_clk <= ~div_clk;
            end
            else
                div_cnt <= div_cnt + 8'h01;
        end
    end

    // Lock indicator
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            lock_indicator_o <= 1'b0;
        else if (ce && ctrl[`DISC_CTRL_EXTCLK])
            lock_indicator_o <= div_clk;
        else if (ce)
            lock_indicator_o <= pll_locked_i;
    end

    // Sleep sets from the pin without any clock and clears on the next clock edge
    always_ff @(posedge clock_i or posedge sleep_i)
    begin
        if (sleep_i)
            sleep_o <= 1'b1;
        else
            sleep_o <= 1'b0;
    end

    // Channel B bus order and midscale forcing
    always_comb
    begin
        for (int i = 0; i < 16; i++)
            b_in[i] = ctrl[`DISC_CTRL_REVB] ? channel_b_data_i[15-i] : channel_b_data_i[i];
        if (!te_sync[1])
        begin
            next_a = `DISC_MIDSCALE;
            next_b = `DISC_MIDSCALE;
        end
        else if (ctrl[`DISC_CTRL_ILEAVE])
        begin
            next_a = a_hold;
            next_b = channel_a_data_i;
        end
        else
        begin
            next_a = channel_a_data_i;
            next_b = b_in;
        end
    end

    // Interleave pointer and word capture on the data clock
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan   <= DISC_CH_IDL;
            a_hold <= `DISC_MIDSCALE;
        end
        else if (ce && fifo_wready && ctrl[`DISC_CTRL_ILEAVE] && te_sync[1])
        begin
            if (te_rise || (ctrl[`DISC_CTRL_FLAGEN] && !channel_flag_i))
            begin
                a_hold <= channel_a_data_i;
                chan   <= DISC_CH_B;
            end
            else if (ctrl[`DISC_CTRL_FLAGEN])
                chan <= DISC_CH_A;
            else
            begin
                unique case (chan)
                    DISC_CH_A:
                    begin
                        a_hold <= channel_a_data_i;
                        chan   <= DISC_CH_B;
                    end
                    DISC_CH_B:
                        chan <= DISC_CH_A;
                    default:
                        chan <= DISC_CH_IDL;
                endcase
            end
        end
    end

    disc_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo
    (
        .clock_i  (clock_i),
        .rstn_i   (rst_n),
        .ce_i     (ce),
        .wdata_i  ({next_a, next_b}),
        .wvalid_i (pair_valid),
        .wready_o (fifo_wready),
        .rdata_o  (fifo_rdata),
        .rvalid_o (fifo_rvalid),
        .rready_i (sample_ready_i | ~sample_valid_o)
    );
    assign pair_valid = ce && fifo_wready && (
                        (!ctrl[`DISC_CTRL_ILEAVE] || !te_sync[1]) ||
                        (!te_rise && ctrl[`DISC_CTRL_FLAGEN] && channel_flag_i) ||
                        (!te_rise && !ctrl[`DISC_CTRL_FLAGEN] && chan == DISC_CH_B));

    // Output register stage
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_o       <= {`DISC_MIDSCALE, `DISC_MIDSCALE};
            sample_valid_o <= 1'b0;
        end
        else if (ce && (sample_ready_i || !sample_valid_o))
        begin
            sample_valid_o <= fifo_rvalid;
            if (fifo_rvalid)
                sample_o <= fifo_rdata;
        end
    end

    // Serial pin roles, bit 0 selects four-pin, bit 1 is the read data level
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_data_o        <= 1'b0;
            serial_data_oe_o     <= 1'b0;
            serial_data_out_o    <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end
        else
        begin
            serial_data_o        <= ser_ctl[1];
            serial_data_oe_o     <= !ser_ctl[0] && !serial_port_enable_n_i;
            serial_data_out_o    <= ser_ctl[1];
            serial_data_out_oe_o <= ser_ctl[0] && !serial_port_enable_n_i;
        end
    end

    // APB register file
    assign apb_acc = psel_i && penable_i && !pready_o;
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl      <= `DISC_CTRL_RESET;
            div_count <= 8'(`DISC_DIV_DEFAULT);
            ser_ctl   <= 2'b00;
            ser_rd    <= 32'h0000_0000;
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o  <= apb_acc;
            pslverr_o <= 1'b0;
            ser_rd    <= {31'h0000_0000, serial_data_i};
            if (apb_acc)
            begin
                prdata_o <= 32'h0000_0000;
                unique case (paddr_i)
                    `DISC_ADDR_CTRL:
                    begin
                        prdata_o <= {26'h000_0000, ctrl[5:0]};
                        if (pwrite_i)
                            ctrl <= {26'h000_0000, pwdata_i[5:0]};
                    end
                    `DISC_ADDR_STATUS:
                    begin
                        prdata_o <= {26'h000_0000, test_select_i, sleep_o, chan, te_sync[1], lock_indicator_o};
                    end
                    `DISC_ADDR_DIVCNT:
                    begin
                        prdata_o <= {24'h00_0000, div_count};
                        if (pwrite_i && pwdata_i[7:0] != 8'h00)
                            div_count <= pwdata_i[7:0];
                    end
                    `DISC_ADDR_SERCTL:
                    begin
                        prdata_o <= {30'h0000_0000, ser_ctl};
                        if (pwrite_i)
                            ser_ctl <= pwdata_i[1:0];
                    end
                    `DISC_ADDR_SERRD:
                        prdata_o <= ser_rd;
                    default:
                        pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule : disc_top

`default_nettype wire

/* File: disc_defs.svh */
// Constants for the converter input sync and control block.
// Assumes inclusion by bare name from the design file.
`ifndef DISC_DEFS_SVH
`define DISC_DEFS_SVH
`define DISC_ADDR_CTRL    12'h000
`define DISC_ADDR_STATUS  12'h004
`define DISC_ADDR_DIVCNT  12'h008
`define DISC_ADDR_SERCTL  12'h00C
`define DISC_ADDR_SERRD   12'h010
`define DISC_CTRL_SYNCSEL 0
`define DISC_CTRL_EXTCLK  1
`define DISC_CTRL_ILEAVE  2
`define DISC_CTRL_FLAGEN  3
`define DISC_CTRL_REVB    4
`define DISC_CTRL_LOCK_INDICATOR 5
`define DISC_CTRL_RESET   32'h0000_0000
`define DISC_MIDSCALE     16'h8000
`define DISC_DIV_DEFAULT  4
`endif

/* File: disc_pkg.sv */
// Types for the converter input sync and control block.
// Assumes no surroundings beyond the design file that imports it.
package disc_pkg;
    typedef enum logic [1:0]
    {
        DISC_CH_A   = 2'b00,
        DISC_CH_B   = 2'b01,
        DISC_CH_IDL = 2'b10
    } disc_chan_type;
    typedef logic [15:0] disc_word_type;
endpackage : disc_pkg

/* File: disc_top_fix_note.sv */
// Intentionally empty: no additional logic.

/* File: disc_top_assertions.sv */
// Port checker for the converter sync and control block.
// Assumes binding to disc_top with one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "disc_defs.svh"
module disc_chk
(
    // Clock and resets
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        chip_reset_n_i,
    input wire logic        ce_i,
    // Control pins
    input wire logic        sleep_i,
    input wire logic        pll_locked_i,
    input wire logic        phase_strobe_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Outputs
    input wire logic        serial_data_oe_o,
    input wire logic        serial_data_out_oe_o,
    input wire logic        lock_indicator_o,
    input wire logic        phase_clear_o,
    input wire logic        sleep_o
);
    logic       ext;
    logic       four;
    logic       quiet;
    logic [4:0] run;
    logic       wr_done;
    assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
    assign quiet   = ce_i && !sleep_i && !sleep_o;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i || !chip_reset_n_i);
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ext  <= 1'h0;
            four <= 1'h0;
        end
        else if (!chip_reset_n_i)
        begin
            ext  <= 1'h0;
            four <= 1'h0;
        end
        else if (wr_done && paddr_i == `DISC_ADDR_CTRL)
            ext <= pwdata_i[`DISC_CTRL_EXTCLK];
        else if (wr_done && paddr_i == `DISC_ADDR_SERCTL)
            four <= pwdata_i[0];
    end
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            run <= 5'h00;
        else if (!ext || !quiet || phase_strobe_i || $changed(lock_indicator_o))
            run <= 5'h00;
        else if (run != 5'h1f)
            run <= run + 5'h01;
    end
    a_apb_ready_next: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready late");
    a_apb_err_gate: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
        else $error("pslverr outside access");
    a_phase_clr_set: assert property ((phase_strobe_i && quiet)[*5] |-> phase_clear_o)
        else $error("phase clear missing");
    a_phase_clr_idle: assert property ((!phase_strobe_i)[*5] |-> !phase_clear_o)
        else $error("phase clear without strobe");
    a_lock_follow: assert property ((!ext && quiet && $stable(pll_locked_i))[*3] |-> lock_indicator_o == pll_locked_i)
        else $error("lock indicator wrong");
    a_lock_toggles: assert property (ext |-> run <= 5'h0c)
        else $error("input rate clock stuck");
    a_sleep_set: assert property (sleep_i |-> ##[0:1] sleep_o)
        else $error("sleep not taken");
    a_three_pin_out: assert property ((!four)[*3] |-> !serial_data_out_oe_o)
        else $error("serial out driven in three-pin mode");
    a_four_pin_in: assert property (four[*3] |-> !serial_data_oe_o)
        else $error("serial data driven in four-pin mode");
endmodule : disc_chk
bind disc_top disc_chk i_chk (.clock_i, .rstn_i, .chip_reset_n_i, .ce_i, .sleep_i, .pll_locked_i,
    .phase_strobe_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
    .serial_data_oe_o, .serial_data_out_oe_o, .lock_indicator_o, .phase_clear_o, .sleep_o);
`default_nettype wire

/* File: disc_src_model.sv */
// Data source and controller model facing the block.
// Assumes the bench steers its mode between clock edges.
`timescale 1ns/100ps
`default_nettype none
module disc_src
(
    // Clock and steering
    input  wire logic        clock_i,
    input  wire logic        count_i,
    input  wire logic        flag_run_i,
    input  wire logic        te_i,
    input  wire logic [15:0] a_val_i,
    input  wire logic [15:0] b_val_i,
    // Pins toward the block
    output logic      [15:0] a_o = 16'h0000,
    output logic      [15:0] b_o = 16'h0000,
    output logic             te_o = 1'h0,
    output logic             flag_o = 1'h0,
    output logic             test_select_o,
    output logic             serial_port_enable_n_o
);
    assign test_select_o          = 1'h0;
    assign serial_port_enable_n_o = 1'h0;
    always @(posedge clock_i)
    begin
        te_o   <= te_i;
        a_o    <= count_i ? a_o + 16'h0001 : a_val_i;
        b_o    <= b_val_i;
        flag_o <= flag_run_i & ~flag_o;
    end
endmodule : disc_src
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the converter sync and control block.
// Assumes design, checker and source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "disc_defs.svh"
module tb_top;
    import disc_pkg::*;
    typedef struct packed {logic [7:0] c; logic t; logic f; logic [15:0] a; logic [15:0] b;
                           logic [31:0] x;} disc_row_type;
    disc_row_type rows [6] = '{'{8'h00, 1'h1, 1'h0, 16'h1234, 16'hABCD, 32'h1234_ABCD},
        '{8'h10, 1'h1, 1'h0, 16'h1234, 16'h0003, 32'h1234_C000}, '{8'h04, 1'h1, 1'h0, 16'h5555, 16'h0000, 32'h5555_5555},
        '{8'h0C, 1'h1, 1'h1, 16'h7777, 16'h0000, 32'h7777_7777}, '{8'h04, 1'h0, 1'h0, 16'h1111, 16'h2222, 32'h8000_8000},
        '{8'h00, 1'h0, 1'h0, 16'h1111, 16'h2222, 32'h8000_8000}};
    logic        clk = 1'h0, rstn = 1'h0, crst_n = 1'h1, slp = 1'h0, pll = 1'h0, stb = 1'h0;
    logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0, rdy = 1'h1, cnt = 1'h0, flg = 1'h0, te = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, sample, q, hold;
    logic [15:0] a_val = 16'h0000, b_val = 16'h0000, a, b, last;
    logic        pready, pslverr, sd_oe, serial_data_out, sdo_oe, lock, pclr, slp_q, svalid, te_m, flag, tsel, sen_n, e, sdd;
    int          num_errors = 0, samples_checked = 0, n, k;
    always #4 clk = ~clk;
    disc_src i_src (.clock_i(clk), .count_i(cnt), .flag_run_i(flg), .te_i(te), .a_val_i(a_val), .b_val_i(b_val),
        .a_o(a), .b_o(b), .te_o(te_m), .flag_o(flag), .test_select_o(tsel), .serial_port_enable_n_o(sen_n));
    disc_top #(.DEPTH(32)) i_dut (.clock_i(clk), .ce_i(1'h1), .rstn_i(rstn), .chip_reset_n_i(crst_n),
        .sleep_i(slp), .test_select_i(tsel), .pll_locked_i(pll), .phase_strobe_i(stb), .transmit_enable_i(te_m),
        .channel_flag_i(flag), .channel_a_data_i(a), .channel_b_data_i(b), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_port_enable_n_i(sen_n), .serial_data_i(1'h0), .serial_data_o(sdd),
        .serial_data_oe_o(sd_oe), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
        .lock_indicator_o(lock), .phase_clear_o(pclr), .sleep_o(slp_q), .sample_o(sample),
        .sample_valid_o(svalid), .sample_ready_i(rdy));
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int m;
        m = 0;
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1 && m < 50)
        begin
            @(posedge clk);
            m++;
        end
        chk32(m < 50, 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
        @(posedge clk);
    endtask : apb
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial
    begin
        #(8 * 8000);
        num_errors++;
        finish_test;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        chk32(sample, 32'h8000_8000);
        apb(1'h0, `DISC_ADDR_DIVCNT, 32'h0);
        chk32(q, 32'h4);
        apb(1'h1, `DISC_ADDR_DIVCNT, 32'h0);
        apb(1'h0, `DISC_ADDR_DIVCNT, 32'h0);
        chk32(q, 32'h4);
        apb(1'h0, `DISC_ADDR_STATUS, 32'h0);
        chk32(q & 32'h20, 32'h0);
        apb(1'h0, 12'h014, 32'h0);
        chk32(e, 1'h1);
        for (int i = 0; i < 6; i++)
        begin
            te <= 1'h0;
            apb(1'h1, `DISC_ADDR_CTRL, {24'h00_0000, rows[i].c});
            te    <= rows[i].t;
            flg   <= rows[i].f;
            a_val <= rows[i].a;
            b_val <= rows[i].b;
            repeat (48) @(posedge clk);
            n = 0;
            while (svalid !== 1'h1 && n < 100)
            begin
                @(posedge clk);
                n++;
            end
            chk32(n < 100, 1'h1);
            chk32(sample, rows[i].x);
        end
        apb(1'h1, `DISC_ADDR_CTRL, 32'h4);
        a_val <= 16'h0100;
        repeat (40) @(posedge clk);
        cnt <= 1'h1;
        te  <= 1'h1;
        k = 0;
        n = 0;
        while (k < 3 && n < 200)
        begin
            @(posedge clk);
            n++;
            if (svalid === 1'h1 && sample !== 32'h8000_8000)
            begin
                chk32(sample[15:0], sample[31:16] + 16'h0001);
                if (k > 0)
                    chk32(sample[31:16], last + 16'h0002);
                last = sample[31:16];
                k++;
            end
        end
        chk32(k, 3);
        cnt <= 1'h0;
        rdy <= 1'h0;
        repeat (40) @(posedge clk);
        hold = sample;
        chk32(svalid, 1'h1);
        repeat (4) @(posedge clk);
        chk32(sample, hold);
        rdy <= 1'h1;
        apb(1'h1, `DISC_ADDR_CTRL, 32'h0);
        stb <= 1'h1;
        repeat (6) @(posedge clk);
        chk32(pclr, 1'h1);
        stb <= 1'h0;
        repeat (6) @(posedge clk);
        chk32(pclr, 1'h0);
        apb(1'h1, `DISC_ADDR_CTRL, 32'h1);
        stb <= 1'h1;
        pll <= 1'h1;
        repeat (6) @(posedge clk);
        chk32(pclr, 1'h1);
        chk32(lock, 1'h1);
        stb <= 1'h0;
        pll <= 1'h0;
        repeat (6) @(posedge clk);
        chk32(lock, 1'h0);
        apb(1'h1, `DISC_ADDR_CTRL, 32'h2);
        repeat (12) @(posedge clk);
        k = 0;
        hold[0] = lock;
        repeat (64)
        begin
            @(posedge clk);
            k += (lock !== hold[0]);
            hold[0] = lock;
        end
        chk32(k >= 15 && k <= 17, 1'h1);
        apb(1'h1, `DISC_ADDR_CTRL, 32'h3);
        stb <= 1'h1;
        repeat (8) @(posedge clk);
        chk32(lock, 1'h0);
        @(posedge clk);
        chk32(lock, 1'h1);
        stb <= 1'h0;
        apb(1'h1, `DISC_ADDR_SERCTL, 32'h3);
        repeat (4) @(posedge clk);
        chk32({sdd, serial_data_out, sdo_oe, sd_oe}, 4'hE);
        apb(1'h1, `DISC_ADDR_SERCTL, 32'h0);
        repeat (4) @(posedge clk);
        chk32({sdd, sdo_oe, sd_oe}, 3'h1);
        slp <= 1'h1;
        repeat (2) @(posedge clk);
        chk32(slp_q, 1'h1);
        slp <= 1'h0;
        repeat (4) @(posedge clk);
        chk32(slp_q, 1'h0);
        crst_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk32(sample, 32'h8000_8000);
        crst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, `DISC_ADDR_CTRL, 32'h0);
        chk32(q, 32'h0);
        finish_test;
    end
endmodule : tb_top
`default_nettype wire
